/* File: ir_timer_pkg.sv */
package ir_timer_pkg;
	localparam int          ADDR_W        = 12;
	localparam int          DATA_W        = 32;
	// register byte offsets
	localparam logic [11:0] OFS_CTRL      = 12'h000;
	localparam logic [11:0] OFS_CARRIER   = 12'h004;
	localparam logic [11:0] OFS_MODTIME   = 12'h008;
	localparam logic [11:0] OFS_COUNTER   = 12'h00c;
	localparam logic [11:0] OFS_PWRCTL    = 12'h010;
	localparam logic [11:0] OFS_STATUS    = 12'h014;
	localparam logic [11:0] OFS_IRQ_EN    = 12'h018;
	localparam logic [11:0] OFS_IRQ_CLR   = 12'h01c;
	// control register fields
	localparam int          CTL_EN        = 0;
	localparam int          CTL_MODE      = 1;
	localparam int          CTL_CLKSEL    = 2;
	localparam int          CTL_POL       = 3;
	localparam int          CTL_DATA      = 4;
	localparam int          CTL_RELOAD    = 5;
	localparam int          CTL_RXEDGE_LO = 6;
	localparam int          CTL_DIV_LO    = 8;
	localparam int          DIV_W         = 3;
	// power control fields
	localparam int          PWR_OUT       = 0;
	localparam int          PWR_OE        = 1;
	// status / interrupt bits
	localparam int          ST_INTERVAL   = 0;
	localparam int          ST_OVERFLOW   = 1;
	localparam int          ST_W          = 2;
	// receive edge select codes
	localparam logic [1:0]  EDGE_FALL     = 2'h1;
	localparam logic [1:0]  EDGE_RISE     = 2'h2;
	localparam logic [1:0]  EDGE_BOTH     = 2'h3;
	localparam logic [15:0] CARRIER_RST   = 16'h0000;
	localparam logic [15:0] CNT_MAX       = 16'hffff;
	localparam logic [15:0] CNT_ZERO      = 16'h0000;
endpackage : ir_timer_pkg

/* File: ir_clk_divider.sv */
`timescale 1ns/100ps
module ir_clk_divider #(
	parameter int DIV_W = 3
) (
	// clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// control
	input  wire logic             run,
	input  wire logic [DIV_W-1:0] div_sel,
	// tick out
	output logic                  tick
);
	localparam int CW = (1 << DIV_W);

	logic [CW-1:0] cnt_r;
	logic [CW-1:0] cnt_nxt;
	logic          tick_nxt;
	logic [CW-1:0] mask;

	// one tick every 2**div_sel system clocks
	always_comb begin
		mask     = CW'((64'h1 << div_sel) - 64'h1);
		cnt_nxt  = run ? ((cnt_r & mask) == mask ? '0 : cnt_r + 1'b1) : '0;
		tick_nxt = run && ((cnt_r & mask) == mask);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= '0;
			tick  <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			tick  <= tick_nxt;
		end
	end
endmodule : ir_clk_divider

/* File: ir_carrier_timer.sv */
// The register addresses and register access over APB were decided locally.
`timescale 1ns/100ps
// Overview of operation
// R1: timer disabled: tx pin follows software value and output-enable bits
// R2: carrier high phase is high byte plus one, low phase low byte plus one
// R3: input clock is system clock divided by two to the divider field
// R4: timer runs only while enable bit is set
// R5: transmit loads counter from modulation time then counts down; receive counts up
// R6: counter rollover from max to zero sets overflow flag and interrupt
// R7: clock-select 0 counts carrier cycles, 1 counts every input clock
// R8: enabled idle level of tx pin equals the polarity bit
// R9: data bit 1 puts carrier (inverted by polarity) on pin; 0 holds idle
// R10: transmission starts on enable-or-mode rising while the other is set
// R11: modulation time, carrier, data and polarity latched at start and reload
// R12: after zero: reload counter, resample, update pin, set interval flag
// R13: software ends transmit by selecting receive or clearing enable
// R14: each interval lasts modulation time plus one counter clocks
// R15: receive: counter reloads zero on capture or runs freely, per setting
// R16: on capture copy pin to data bit, counter to modulation time, maybe clear
// R17: all state synchronous; reset leaves timer disabled, pin under software
module ir_carrier_timer
	import ir_timer_pkg::*;
(
	// clock and reset
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	// apb slave
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [ir_timer_pkg::ADDR_W-1:0] paddr,
	input  wire logic [ir_timer_pkg::DATA_W-1:0] pwdata,
	output logic      [ir_timer_pkg::DATA_W-1:0] prdata,
	output logic                             pready,
	output logic                             pslverr,
	// infrared pins
	output logic                             infrared_tx_pin,
	output logic                             infrared_tx_oe,
	input  wire logic                        infrared_rx_pin,
	// interrupt
	output logic                             irq
);
	import ir_timer_pkg::*;

	// control, timing, counter, power, status and interrupt registers
	logic             infrared_timer_enable_r, transmit_mode_select_r, counter_clock_select_r;
	logic             transmit_polarity_r, modulation_data_bit_r, capture_reload_enable_r;
	logic [1:0]       rx_edge_sel_r;
	logic [DIV_W-1:0] infrared_clock_divider_r;
	logic [15:0]      carrier_timing_r, modulation_time_r, interval_counter_r;
	logic             manual_pin_value_r, manual_pin_output_enable_r;
	logic [ST_W-1:0]  status_r, irq_en_r;
	// latched transmit settings
	logic [15:0]      lat_carrier_r;
	logic             lat_pol_r, lat_data_r;
	// carrier generator, transmit state and rx synchroniser
	logic [7:0]       phase_cnt_r;
	logic             phase_hi_r;
	logic             tx_active_r;
	logic             rx_s1_r, rx_s2_r, rx_prev_r;

	logic             wr_en, rd_en, ir_tick, run_tx, run_rx, carrier_end, cnt_tick;
	logic             tx_start, reload, capture, overflow, cnt_wr;
	logic             rx_rise, rx_fall;
	logic [DATA_W-1:0] rd_data;

	ir_clk_divider #(.DIV_W(DIV_W)) u_div (
		.pclk    (pclk),
		.presetn (presetn),
		.run     (infrared_timer_enable_r), // R4
		.div_sel (infrared_clock_divider_r), // R3
		.tick    (ir_tick)
	);

	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && !penable && !pwrite;

	// rx pin synchroniser, second stage feeds edge detect
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_s1_r   <= 1'b0;
			rx_s2_r   <= 1'b0;
			rx_prev_r <= 1'b0;
		end else begin
			rx_s1_r   <= infrared_rx_pin;
			rx_s2_r   <= rx_s1_r;
			rx_prev_r <= rx_s2_r;
		end
	end
	assign rx_rise = rx_s2_r && !rx_prev_r;
	assign rx_fall = !rx_s2_r && rx_prev_r;

	// control decode
	always_comb begin
		run_tx      = infrared_timer_enable_r && transmit_mode_select_r; // R4
		run_rx      = infrared_timer_enable_r && !transmit_mode_select_r;
		// carrier phase ends after byte+1 input clocks
		carrier_end = ir_tick && !phase_hi_r && (phase_cnt_r == 8'h00); // R2
		cnt_tick    = counter_clock_select_r ? ir_tick : carrier_end; // R7
		// R10 start: active flag not yet set while transmit running
		tx_start    = run_tx && !tx_active_r;
		reload      = run_tx && tx_active_r && cnt_tick && (interval_counter_r == CNT_ZERO); // R12 R14
		capture     = run_rx && ((rx_rise && rx_edge_sel_r[1]) || (rx_fall && rx_edge_sel_r[0])); // R16
		cnt_wr      = wr_en && (paddr == OFS_COUNTER);
		overflow    = run_rx && cnt_tick && (interval_counter_r == CNT_MAX) && !cnt_wr
			&& !(capture && capture_reload_enable_r); // R6
	end

	// register file and counter next state
	logic             en_nxt, mode_nxt, clksel_nxt, pol_nxt, data_nxt, rl_nxt;
	logic [1:0]       edge_nxt;
	logic [DIV_W-1:0] div_nxt;
	logic [15:0]      car_nxt, mt_nxt, cnt_nxt, lat_car_nxt;
	logic             mout_nxt, moe_nxt, lat_pol_nxt, lat_data_nxt, act_nxt;
	logic [ST_W-1:0]  st_nxt, ien_nxt;
	logic [7:0]       ph_cnt_nxt;
	logic             ph_hi_nxt;

	always_comb begin
		en_nxt       = infrared_timer_enable_r;
		mode_nxt     = transmit_mode_select_r;
		clksel_nxt   = counter_clock_select_r;
		pol_nxt      = transmit_polarity_r;
		data_nxt     = modulation_data_bit_r;
		rl_nxt       = capture_reload_enable_r;
		edge_nxt     = rx_edge_sel_r;
		div_nxt      = infrared_clock_divider_r;
		car_nxt      = carrier_timing_r;
		mt_nxt       = modulation_time_r;
		mout_nxt     = manual_pin_value_r;
		moe_nxt      = manual_pin_output_enable_r;
		ien_nxt      = irq_en_r;
		st_nxt       = status_r;
		cnt_nxt      = interval_counter_r;
		lat_car_nxt  = lat_carrier_r;
		lat_pol_nxt  = lat_pol_r;
		lat_data_nxt = lat_data_r;
		act_nxt      = run_tx && tx_active_r; // R13
		ph_cnt_nxt   = phase_cnt_r;
		ph_hi_nxt    = phase_hi_r;
		if (wr_en) begin
			unique case (paddr)
				OFS_CTRL: begin
					en_nxt     = pwdata[CTL_EN];
					mode_nxt   = pwdata[CTL_MODE];
					clksel_nxt = pwdata[CTL_CLKSEL];
					pol_nxt    = pwdata[CTL_POL];
					data_nxt   = pwdata[CTL_DATA];
					rl_nxt     = pwdata[CTL_RELOAD];
					edge_nxt   = pwdata[CTL_RXEDGE_LO +: 2];
					div_nxt    = pwdata[CTL_DIV_LO +: DIV_W];
				end
				OFS_CARRIER: car_nxt = pwdata[15:0];
				OFS_MODTIME: mt_nxt = pwdata[15:0];
				OFS_COUNTER: cnt_nxt = pwdata[15:0];
				OFS_PWRCTL: begin
					mout_nxt = pwdata[PWR_OUT];
					moe_nxt  = pwdata[PWR_OE];
				end
				OFS_IRQ_EN: ien_nxt = pwdata[ST_W-1:0];
				OFS_IRQ_CLR: st_nxt = status_r & ~pwdata[ST_W-1:0];
				default: ;
			endcase
		end
		// carrier generator, restarted at every latch point
		if (!infrared_timer_enable_r || tx_start || reload) begin
			ph_hi_nxt  = 1'b1;
			ph_cnt_nxt = carrier_timing_r[15:8]; // R2 R11
		end else if (ir_tick) begin
			if (phase_cnt_r != 8'h00) begin
				ph_cnt_nxt = phase_cnt_r - 8'h01;
			end else if (phase_hi_r) begin
				ph_hi_nxt  = 1'b0;
				ph_cnt_nxt = lat_carrier_r[7:0]; // R2
			end else begin
				ph_hi_nxt  = 1'b1;
				ph_cnt_nxt = lat_carrier_r[15:8];
			end
		end
		if (tx_start || reload) begin
			// R5 R11 R12 latch settings and reload
			act_nxt      = 1'b1;
			cnt_nxt      = modulation_time_r;
			lat_car_nxt  = carrier_timing_r;
			lat_pol_nxt  = transmit_polarity_r;
			lat_data_nxt = modulation_data_bit_r;
		end else if (run_tx && cnt_tick) begin
			cnt_nxt = interval_counter_r - 16'h0001; // R5
		end else if (capture) begin
			data_nxt = rx_s2_r; // R16
			mt_nxt   = interval_counter_r;
			cnt_nxt  = capture_reload_enable_r ? CNT_ZERO : interval_counter_r + 16'h0001; // R15
			if (!cnt_tick) begin
				cnt_nxt = capture_reload_enable_r ? CNT_ZERO : interval_counter_r;
			end
		end else if (run_rx && cnt_tick) begin
			cnt_nxt = interval_counter_r + 16'h0001; // R5 R6
		end
		// software start value wins over counting, not over a start or reload
		if (cnt_wr && !tx_start && !reload) begin
			cnt_nxt = pwdata[15:0];
		end
		// hardware set wins over software clear
		if (reload) begin
			st_nxt[ST_INTERVAL] = 1'b1; // R12
		end
		if (overflow) begin
			st_nxt[ST_OVERFLOW] = 1'b1; // R6
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			infrared_timer_enable_r    <= 1'b0; // R17
			transmit_mode_select_r     <= 1'b0;
			counter_clock_select_r     <= 1'b0;
			transmit_polarity_r        <= 1'b0;
			modulation_data_bit_r      <= 1'b0;
			capture_reload_enable_r    <= 1'b0;
			rx_edge_sel_r              <= 2'h0;
			infrared_clock_divider_r   <= '0;
			carrier_timing_r           <= CARRIER_RST;
			modulation_time_r          <= CNT_ZERO;
			interval_counter_r         <= CNT_ZERO;
			manual_pin_value_r         <= 1'b0;
			manual_pin_output_enable_r <= 1'b0;
			status_r                   <= '0;
			irq_en_r                   <= '0;
			lat_carrier_r              <= CARRIER_RST;
			lat_pol_r                  <= 1'b0;
			lat_data_r                 <= 1'b0;
			tx_active_r                <= 1'b0;
			phase_cnt_r                <= 8'h00;
			phase_hi_r                 <= 1'b1;
		end else begin
			infrared_timer_enable_r    <= en_nxt;
			transmit_mode_select_r     <= mode_nxt;
			counter_clock_select_r     <= clksel_nxt;
			transmit_polarity_r        <= pol_nxt;
			modulation_data_bit_r      <= data_nxt;
			capture_reload_enable_r    <= rl_nxt;
			rx_edge_sel_r              <= edge_nxt;
			infrared_clock_divider_r   <= div_nxt;
			carrier_timing_r           <= car_nxt;
			modulation_time_r          <= mt_nxt;
			interval_counter_r         <= cnt_nxt;
			manual_pin_value_r         <= mout_nxt;
			manual_pin_output_enable_r <= moe_nxt;
			status_r                   <= st_nxt;
			irq_en_r                   <= ien_nxt;
			lat_carrier_r              <= lat_car_nxt;
			lat_pol_r                  <= lat_pol_nxt;
			lat_data_r                 <= lat_data_nxt;
			tx_active_r                <= act_nxt;
			phase_cnt_r                <= ph_cnt_nxt;
			phase_hi_r                 <= ph_hi_nxt;
		end
	end

	// pin and bus outputs
	logic tx_nxt, oe_nxt, irq_nxt;
	always_comb begin
		if (!infrared_timer_enable_r) begin
			tx_nxt = manual_pin_value_r; // R1
			oe_nxt = manual_pin_output_enable_r;
		end else if (tx_active_r) begin
			tx_nxt = lat_data_r ? (phase_hi_r ^ lat_pol_r) : lat_pol_r; // R9
			oe_nxt = 1'b1;
		end else begin
			tx_nxt = transmit_polarity_r; // R8
			oe_nxt = 1'b1;
		end
		irq_nxt = |(st_nxt & ien_nxt);
		rd_data = '0;
		unique case (paddr)
			OFS_CTRL: begin
				rd_data[CTL_EN]                = infrared_timer_enable_r;
				rd_data[CTL_MODE]              = transmit_mode_select_r;
				rd_data[CTL_CLKSEL]            = counter_clock_select_r;
				rd_data[CTL_POL]               = transmit_polarity_r;
				rd_data[CTL_DATA]              = modulation_data_bit_r;
				rd_data[CTL_RELOAD]            = capture_reload_enable_r;
				rd_data[CTL_RXEDGE_LO +: 2]    = rx_edge_sel_r;
				rd_data[CTL_DIV_LO +: DIV_W]   = infrared_clock_divider_r;
			end
			OFS_CARRIER: rd_data[15:0] = carrier_timing_r;
			OFS_MODTIME: rd_data[15:0] = modulation_time_r;
			OFS_COUNTER: rd_data[15:0] = interval_counter_r;
			OFS_PWRCTL: begin
				rd_data[PWR_OUT] = manual_pin_value_r;
				rd_data[PWR_OE]  = manual_pin_output_enable_r;
			end
			OFS_STATUS: rd_data[ST_W-1:0] = status_r;
			OFS_IRQ_EN: rd_data[ST_W-1:0] = irq_en_r;
			default: ;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			infrared_tx_pin <= 1'b0;
			infrared_tx_oe  <= 1'b0;
			irq             <= 1'b0;
			prdata          <= '0;
			pready          <= 1'b0;
			pslverr         <= 1'b0;
		end else begin
			infrared_tx_pin <= tx_nxt;
			infrared_tx_oe  <= oe_nxt;
			irq             <= irq_nxt;
			if (rd_en) begin
				prdata <= rd_data;
			end
			pready  <= psel && !penable;
			pslverr <= 1'b0;
		end
	end

	// assertions
	property p_idle_manual;
		@(posedge pclk) disable iff (!presetn)
		!infrared_timer_enable_r |=> (infrared_tx_pin == $past(manual_pin_value_r));
	endproperty
	a_idle_manual: assert property (p_idle_manual) else $error("manual pin value not driven"); // R1

	property p_reload_value;
		@(posedge pclk) disable iff (!presetn)
		reload |=> (interval_counter_r == $past(modulation_time_r)) && status_r[ST_INTERVAL];
	endproperty
	a_reload_value: assert property (p_reload_value) else $error("reload missed"); // R12

	property p_overflow_flag;
		@(posedge pclk) disable iff (!presetn)
		overflow |=> status_r[ST_OVERFLOW] && (interval_counter_r == CNT_ZERO);
	endproperty
	a_overflow_flag: assert property (p_overflow_flag) else $error("overflow flag not set"); // R6

	property p_disabled_stops;
		@(posedge pclk) disable iff (!presetn)
		!infrared_timer_enable_r ##1 !infrared_timer_enable_r |-> !tx_active_r && !ir_tick;
	endproperty
	a_disabled_stops: assert property (p_disabled_stops) else $error("timer runs while disabled"); // R4

	property p_tx_start;
		@(posedge pclk) disable iff (!presetn)
		tx_start |=> tx_active_r && (lat_pol_r == $past(transmit_polarity_r));
	endproperty
	a_tx_start: assert property (p_tx_start) else $error("transmit did not start"); // R10

	property p_down_count;
		@(posedge pclk) disable iff (!presetn)
		(run_tx && tx_active_r && cnt_tick && interval_counter_r != CNT_ZERO && !wr_en)
			|=> interval_counter_r == $past(interval_counter_r) - 16'h0001;
	endproperty
	a_down_count: assert property (p_down_count) else $error("down count wrong"); // R5

	property p_capture;
		@(posedge pclk) disable iff (!presetn)
		(capture && !wr_en) |=> (modulation_time_r == $past(interval_counter_r))
			&& (modulation_data_bit_r == $past(rx_s2_r));
	endproperty
	a_capture: assert property (p_capture) else $error("capture wrong"); // R16

	property p_irq;
		@(posedge pclk) disable iff (!presetn)
		irq == |(status_r & irq_en_r);
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt level wrong"); // R6
endmodule : ir_carrier_timer

/* File: ir_far_side.sv */
`timescale 1ns/100ps
module ir_far_side (
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// emitter side
	input  wire logic tx_pin,
	input  wire logic tx_oe,
	// receiver side
	output logic      rx_pin
);
	int   run_len;
	int   high_len;
	int   low_len;
	int   toggles;
	logic last_r;
	initial rx_pin = 1'b0;
	// receiver output, changed just after a clock edge
	task automatic drive_rx(input logic v);
		@(posedge pclk);
		rx_pin <= v;
	endtask : drive_rx
	// emitter: length of each lit and dark phase in pclk cycles
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_len  <= 0;
			high_len <= 0;
			low_len  <= 0;
			toggles  <= 0;
			last_r   <= 1'b0;
		end else begin
			last_r <= tx_pin;
			if (tx_oe && tx_pin !== last_r) begin
				if (last_r)
					high_len <= run_len;
				else
					low_len <= run_len;
				toggles <= toggles + 1;
				run_len <= 1;
			end else
				run_len <= run_len + 1;
		end
	end
endmodule : ir_far_side

/* File: infrared_carrier_modulation_timer_bench.sv */
`timescale 1ns/100ps
module infrared_carrier_modulation_timer_bench;
	import ir_timer_pkg::*;
	localparam logic [31:0] B_EN  = 32'h1 << CTL_EN;
	localparam logic [31:0] B_TX  = 32'h1 << CTL_MODE;
	localparam logic [31:0] B_CS  = 32'h1 << CTL_CLKSEL;
	localparam logic [31:0] B_POL = 32'h1 << CTL_POL;
	localparam logic [31:0] B_DAT = 32'h1 << CTL_DATA;
	localparam logic [31:0] B_RL  = 32'h1 << CTL_RELOAD;
	localparam logic [31:0] B_DV1 = 32'h1 << CTL_DIV_LO;
	localparam logic [31:0] B_EDG = 32'(EDGE_BOTH) << CTL_RXEDGE_LO;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        tx;
	logic        oe;
	logic        rx;
	logic        irq;
	logic [31:0] q;
	logic [31:0] q1;
	int          mismatches = 0;
	int          tests_run = 0;
	int          cyc = 0;
	int          t1;
	ir_carrier_timer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.infrared_tx_pin(tx), .infrared_tx_oe(oe), .infrared_rx_pin(rx), .irq(irq));
	ir_far_side far_u (.pclk(pclk), .presetn(presetn), .tx_pin(tx), .tx_oe(oe), .rx_pin(rx));
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	always @(posedge pclk) cyc <= cyc + 1;
	task automatic results();
		$display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : results
	task automatic fail(input string m);
		mismatches++;
		$display("MISMATCH t=%0t %s", $time, m);
	endtask : fail
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e)
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		if (g !== e)
			mismatches++;
	endtask : chk
	task automatic chk_rng(input logic [31:0] g, input logic [31:0] lo, input logic [31:0] hi);
		tests_run++;
		if ((g >= lo && g <= hi) !== 1'b1)
			fail($sformatf("got %h outside %h..%h", g, lo, hi));
	endtask : chk_rng
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		q = prdata;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			fail("apb timeout");
			results();
		end
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [11:0] a);
		apb(1'b0, a, 32'h0);
	endtask : rd
	task automatic wait_irq(input logic v);
		int n;
		n = 0;
		while (irq !== v && n < 3000) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 3000) begin
			fail("irq wait timeout");
			results();
		end
	endtask : wait_irq
	task automatic t_reset();
		chk({oe, tx, irq}, 3'h0);
		rd(OFS_CTRL);
		chk(q, 32'h0);
		rd(OFS_CARRIER);
		chk(q, 32'(CARRIER_RST));
		rd(12'h020);
		chk(q, 32'h0);
		chk(pslverr, 1'b0);
		$display("test reset done");
	endtask : t_reset
	task automatic t_manual();
		wr(OFS_PWRCTL, 32'h3);
		repeat (3) @(posedge pclk);
		chk({oe, tx}, 2'h3);
		wr(OFS_PWRCTL, 32'h1 << PWR_OE);
		repeat (3) @(posedge pclk);
		chk({oe, tx}, 2'h2);
		wr(OFS_PWRCTL, 32'h0);
		repeat (3) @(posedge pclk);
		chk(oe, 1'b0);
		$display("test manual pin done");
	endtask : t_manual
	task automatic t_idle();
		wr(OFS_CTRL, B_EN | B_TX | B_POL);
		repeat (4) @(posedge pclk);
		t1 = far_u.toggles;
		chk({oe, tx}, 2'h3);
		repeat (60) @(posedge pclk);
		chk(32'(far_u.toggles - t1), 32'h0);
		wr(OFS_CTRL, B_EN | B_TX);
		repeat (4) @(posedge pclk);
		chk({oe, tx}, 2'h2);
		wr(OFS_CTRL, 32'h0);
		$display("test idle level done");
	endtask : t_idle
	task automatic t_carrier();
		wr(OFS_CARRIER, 32'h0201);
		wr(OFS_MODTIME, 32'h00ff);
		wr(OFS_CTRL, B_EN | B_TX | B_DAT | B_DV1);
		repeat (60) @(posedge pclk);
		chk(32'(far_u.high_len), 32'd6);
		chk(32'(far_u.low_len), 32'd4);
		wr(OFS_CTRL, B_EN | B_POL | B_DAT | B_DV1);
		wr(OFS_CTRL, B_EN | B_TX | B_POL | B_DAT | B_DV1);
		repeat (60) @(posedge pclk);
		chk(32'(far_u.high_len), 32'd4);
		chk(32'(far_u.low_len), 32'd6);
		wr(OFS_CTRL, 32'h0);
		$display("test carrier done");
	endtask : t_carrier
	task automatic t_interval(input logic [31:0] cs, input logic [31:0] mt, input logic [31:0] ca,
		input logic [31:0] exp_len);
		wr(OFS_IRQ_CLR, 32'h3);
		wr(OFS_IRQ_EN, 32'h1 << ST_INTERVAL);
		wr(OFS_CARRIER, ca);
		wr(OFS_MODTIME, mt);
		wr(OFS_CTRL, B_EN | B_TX | cs);
		wait_irq(1'b1);
		t1 = cyc;
		wr(OFS_IRQ_CLR, 32'h1 << ST_INTERVAL);
		wait_irq(1'b0);
		wait_irq(1'b1);
		chk(32'(cyc - t1), exp_len);
		wr(OFS_IRQ_EN, 32'h0);
		repeat (3) @(posedge pclk);
		chk(irq, 1'b0);
		rd(OFS_STATUS);
		chk(q[ST_INTERVAL], 1'b1);
		wr(OFS_CTRL, B_EN);
		wr(OFS_IRQ_CLR, 32'h3);
		repeat (2 * exp_len) @(posedge pclk);
		rd(OFS_STATUS);
		chk(q[ST_INTERVAL], 1'b0);
		wr(OFS_CTRL, 32'h0);
		$display("test interval done");
	endtask : t_interval
	task automatic t_receive();
		wr(OFS_IRQ_CLR, 32'h3);
		wr(OFS_CTRL, B_EN | B_CS | B_RL | B_EDG);
		far_u.drive_rx(1'b1);
		repeat (39) @(posedge pclk);
		far_u.drive_rx(1'b0);
		repeat (10) @(posedge pclk);
		rd(OFS_MODTIME);
		chk_rng(q, 32'd39, 32'd41);
		rd(OFS_CTRL);
		chk(q[CTL_DATA], 1'b0);
		far_u.drive_rx(1'b1);
		repeat (6) @(posedge pclk);
		rd(OFS_CTRL);
		chk(q[CTL_DATA], 1'b1);
		rd(OFS_COUNTER);
		chk_rng(q, 32'd0, 32'd20);
		wr(OFS_CTRL, B_EN | B_CS | B_EDG);
		rd(OFS_COUNTER);
		q1 = q;
		far_u.drive_rx(1'b0);
		repeat (6) @(posedge pclk);
		rd(OFS_COUNTER);
		chk_rng(q, q1 + 32'd7, q1 + 32'd20);
		wr(OFS_IRQ_EN, 32'h1 << ST_OVERFLOW);
		wr(OFS_COUNTER, 32'h0000_ffd0);
		rd(OFS_COUNTER);
		q1 = q;
		rd(OFS_COUNTER);
		chk_rng(q, q1 + 32'd1, q1 + 32'd20);
		wait_irq(1'b1);
		rd(OFS_STATUS);
		chk(q[ST_OVERFLOW], 1'b1);
		rd(OFS_COUNTER);
		chk_rng(q, 32'd0, 32'h100);
		wr(OFS_CTRL, 32'h0);
		wr(OFS_IRQ_CLR, 32'h3);
		repeat (3) @(posedge pclk);
		chk(irq, 1'b0);
		$display("test receive done");
	endtask : t_receive
	initial begin
		presetn = 1'b0;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 12'h000;
		pwdata  = 32'h0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_manual();
		t_idle();
		t_carrier();
		t_interval(B_CS, 32'd19, 32'h0000, 32'd20);
		t_interval(32'h0, 32'd9, 32'h0100, 32'd30);
		t_receive();
		results();
	end
endmodule : infrared_carrier_modulation_timer_bench
